// *** design/spc_power_ctrl.v ***
// Purpose: run/idle/sleep power-mode controller with bus clock scaling
// Assumes: one system clock; halt pulse and priorities from the cpu side
// Notes:   clock gates are enables; actual gating cells sit outside
`timescale 1ns/1ps
`include "spc_consts.vh"

module spc_power_ctrl #(
  parameter NUM_PBUS   = 7,
  parameter NUM_PERIPH = 8,
  parameter PRIO_W     = 3,
  parameter SU_SLOW    = `SPC_SU_SLOW_CYC
) (
  // clock and reset
  input  wire                           clk,
  input  wire                           nrst,
  // cpu side
  input  wire                           halt_exec,
  input  wire [PRIO_W-1:0]              cpu_prio,
  input  wire [`SPC_OSC_W-1:0]          oscillator_control_reg,
  input  wire                           slow_osc_sel,
  input  wire [`SPC_DIV_W-1:0]          cpu_div,
  // interrupt controller
  input  wire                           irq_pend,
  input  wire [PRIO_W-1:0]              irq_prio,
  input  wire                           irq_sleep_src,
  input  wire                           watchdog_timeout,
  // peripheral configuration
  input  wire [NUM_PBUS*`SPC_DIV_W-1:0] pbus_div,
  input  wire [NUM_PBUS-1:0]            pbus_off,
  input  wire [NUM_PERIPH-1:0]          stop_in_idle_bit,
  input  wire [NUM_PERIPH-1:0]          sleep_capable,
  input  wire                           monitor_en,
  // status and clock enables
  output reg  [1:0]                     pwr_state,
  output reg                            cpu_halted,
  output reg                            cpu_clk_en,
  output reg  [NUM_PBUS-1:0]            peripheral_bus_clock_n,
  output reg  [NUM_PERIPH-1:0]          periph_run,
  output reg                            clock_failure_monitor,
  output reg                            brownout_reset_circuit,
  output reg                            watchdog_clear,
  output reg                            pin_hold
);

  ////////////////////////////////////////////////////////////////////
  // state machine
  localparam [1:0] ST_RUN   = `SPC_ST_RUN;
  localparam [1:0] ST_IDLE  = `SPC_ST_IDLE;
  localparam [1:0] ST_SLEEP = `SPC_ST_SLEEP;
  localparam [1:0] ST_WAKE  = `SPC_ST_WAKE;
  localparam [16:0] SU_FAST_C = `SPC_SU_FAST_CYC;

  reg  [1:0]  st_q;
  reg  [1:0]  st_d;
  reg  [16:0] su_cnt_q;
  reg  [16:0] su_cnt_d;
  wire        sleep_sel = oscillator_control_reg[`SPC_OSC_SLEEP_BIT];
  wire        prio_win  = irq_pend && (irq_prio > cpu_prio);
  wire        sleep_irq = prio_win && irq_sleep_src;
  wire        low_irq   = irq_pend && irq_sleep_src && !(irq_prio > cpu_prio);
  wire [16:0] su_len    = slow_osc_sel ? SU_SLOW[16:0] : SU_FAST_C;

  always @* begin
    st_d     = st_q;
    su_cnt_d = su_cnt_q;
    case (st_q)
      ST_RUN: begin
        // only the halt instruction leaves run
        if (halt_exec) begin
          if (sleep_sel)
            st_d = ST_SLEEP;
          else
            st_d = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (prio_win || watchdog_timeout)
          st_d = ST_RUN;
      end
      ST_SLEEP: begin
        if (sleep_irq || watchdog_timeout) begin
          st_d     = ST_WAKE;
          su_cnt_d = su_len;
        end else if (low_irq) begin
          st_d = ST_IDLE;
        end
      end
      ST_WAKE: begin
        // oscillator restarts before code resumes
        if (su_cnt_q <= 17'h00001)
          st_d = ST_RUN;
        else
          su_cnt_d = su_cnt_q - 17'h00001;
      end
      default: st_d = ST_RUN;
    endcase
  end

  // device reset wakes from any state through the async clear
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_q     <= ST_RUN;
      su_cnt_q <= 17'h00000;
    end else begin
      st_q     <= st_d;
      su_cnt_q <= su_cnt_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // dividers: one enable pulse per bus, counters rather than gated clocks
  reg  [`SPC_DIV_W-1:0]          cpu_cnt_q;
  reg  [NUM_PBUS*`SPC_DIV_W-1:0] pb_cnt_q;
  wire                           cpu_tick = (cpu_cnt_q >= cpu_div);

  always @(posedge clk or negedge nrst) begin
    if (!nrst)
      cpu_cnt_q <= `SPC_DIV_RESET;
    else if (cpu_tick)
      cpu_cnt_q <= `SPC_DIV_RESET;
    else
      cpu_cnt_q <= cpu_cnt_q + 4'h1;
  end

  wire [NUM_PBUS-1:0] pb_tick;
  wire                bus_awake = (st_d != ST_SLEEP) && (st_d != ST_WAKE);
  genvar g;
  generate
    for (g = 0; g < NUM_PBUS; g = g + 1) begin : g_pbus
      wire [`SPC_DIV_W-1:0] div = pbus_div[g*`SPC_DIV_W +: `SPC_DIV_W];
      wire [`SPC_DIV_W-1:0] cnt = pb_cnt_q[g*`SPC_DIV_W +: `SPC_DIV_W];
      assign pb_tick[g] = (cnt >= div);
      always @(posedge clk or negedge nrst) begin
        if (!nrst)
          pb_cnt_q[g*`SPC_DIV_W +: `SPC_DIV_W] <= `SPC_DIV_RESET;
        else if (pb_tick[g])
          pb_cnt_q[g*`SPC_DIV_W +: `SPC_DIV_W] <= `SPC_DIV_RESET;
        else
          pb_cnt_q[g*`SPC_DIV_W +: `SPC_DIV_W] <= cnt + 4'h1;
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////
  // outputs, registered from the next state so they line up with st_q
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pwr_state              <= `SPC_ST_RUN;
      cpu_halted             <= 1'b0;
      cpu_clk_en             <= 1'b0;
      peripheral_bus_clock_n <= {NUM_PBUS{1'b0}};
      periph_run             <= {NUM_PERIPH{1'b1}};
      clock_failure_monitor  <= 1'b0;
      brownout_reset_circuit <= 1'b1;
      watchdog_clear         <= 1'b0;
      pin_hold               <= 1'b0;
    end else begin
      pwr_state  <= st_d;
      cpu_halted <= (st_d != ST_RUN);
      cpu_clk_en <= (st_d == ST_RUN) && cpu_tick;
      // bus clocks stop in sleep and wake, restart in idle or run
      peripheral_bus_clock_n <= (bus_awake ? pb_tick : {NUM_PBUS{1'b0}})
                                & ~pbus_off;
      case (st_d)
        ST_IDLE:  periph_run <= ~stop_in_idle_bit;
        ST_SLEEP: periph_run <= sleep_capable;
        ST_WAKE:  periph_run <= sleep_capable;
        default:  periph_run <= {NUM_PERIPH{1'b1}};
      endcase
      clock_failure_monitor  <= monitor_en && bus_awake;
      brownout_reset_circuit <= 1'b1;
      watchdog_clear         <= 1'b0;
      // pads keep driving; hold just freezes the output latches
      pin_hold <= !bus_awake;
    end
  end

endmodule // spc_power_ctrl

// *** design/spc_consts.vh ***
// Purpose: constants for the sleep/idle power controller
// Assumes: 10 MHz system clock
// Notes:   timing counts are in clock cycles
`ifndef SPC_CONSTS_VH
`define SPC_CONSTS_VH

// power states
`define SPC_ST_RUN        2'h0
`define SPC_ST_IDLE       2'h1
`define SPC_ST_SLEEP      2'h2
`define SPC_ST_WAKE       2'h3

// oscillator control register layout
`define SPC_OSC_W         8
`define SPC_OSC_SLEEP_BIT 4
`define SPC_OSC_RESET     8'h00

// clock rate and start-up delays
`define SPC_CLK_MHZ       10
`define SPC_SU_FAST_NS    1000
`define SPC_SU_SLOW_NS    100000
`define SPC_SU_FAST_CYC   ((`SPC_SU_FAST_NS * `SPC_CLK_MHZ + 999) / 1000)
`define SPC_SU_SLOW_CYC   ((`SPC_SU_SLOW_NS * `SPC_CLK_MHZ + 999) / 1000)

// peripheral bus divider
`define SPC_DIV_W         4
`define SPC_DIV_RESET     4'h0

`endif

// *** dv/spc_power_chk_assertions.sv ***
// Purpose: power-mode checker
// Assumes: one clock, async low reset
// Notes:   state 0 run, 1 idle, 2 sleep, 3 wake
`timescale 1ns/1ps
module spc_power_chk #(parameter PRIO_W = 3, NUM_PBUS = 7) (
  // clock, reset
  input logic                clk,
  input logic                nrst,
  // cpu and interrupt side
  input logic                halt_exec,
  input logic                watchdog_timeout,
  input logic                irq_pend,
  input logic                irq_sleep_src,
  input logic [PRIO_W-1:0]   cpu_prio,
  input logic [PRIO_W-1:0]   irq_prio,
  input logic [7:0]          oscillator_control_reg,
  // status
  input logic [1:0]          pwr_state,
  input logic [NUM_PBUS-1:0] peripheral_bus_clock_n,
  input logic                clock_failure_monitor,
  input logic                pin_hold
);
  wire run = pwr_state == 2'h0, idl = pwr_state == 2'h1;
  wire slp = pwr_state == 2'h2, wak = pwr_state == 2'h3;
  wire win = irq_pend && irq_prio > cpu_prio, sb = oscillator_control_reg[4];
  wire go = watchdog_timeout || win && irq_sleep_src;
  wire lose = irq_pend && !win && !watchdog_timeout;
  wire quiet = !(|peripheral_bus_clock_n) && !clock_failure_monitor && pin_hold;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////
  idle_entry_a: assert property (run && halt_exec && !sb |=> idl) else $error("no idle");
  sleep_entry_a: assert property (run && halt_exec && sb |=> slp) else $error("no sleep");
  run_stays_a: assert property (run && !halt_exec |=> run) else $error("left run");
  sleep_quiet_a: assert property (slp |-> quiet) else $error("sleep busy");
  idle_wake_a: assert property (idl && (win || watchdog_timeout) |=> run) else $error("idle");
  idle_stay_a: assert property (idl && !win && !watchdog_timeout |=> idl) else $error("idle");
  sleep_wake_a: assert property (slp && go |=> wak) else $error("no wake");
  sleep_idle_a: assert property (slp && irq_sleep_src && lose |=> idl) else $error("s2i");
  cover property (slp ##1 idl);
  cover property (wak ##1 run);
  cover property (idl ##1 run);
endmodule // spc_power_chk
bind spc_power_ctrl spc_power_chk #(.PRIO_W(PRIO_W), .NUM_PBUS(NUM_PBUS)) chk_i (.*);

// *** dv/spc_irq_model.sv ***
// Purpose: interrupt controller stand-in
// Assumes: request pends until the cpu runs
// Notes:   priority and source come from the bench
`timescale 1ns/1ps
module spc_irq_model (
  // clock, reset
  input  logic       clk,
  input  logic       nrst,
  // request, cpu state
  input  logic       fire,
  input  logic [1:0] pwr_state,
  // pending line
  output logic       irq_pend
);
  // a losing request lingers, as a real one would
  always @(posedge clk or negedge nrst) begin
    if (!nrst) irq_pend <= 1'h0;
    else if (fire) irq_pend <= 1'h1;
    else if (pwr_state == 2'h0) irq_pend <= 1'h0;
  end
endmodule // spc_irq_model

// *** dv/sleep_idle_power_control_bench.sv ***
// Purpose: bench for the power controller
// Assumes: inputs move 1 ns after the edge
// Notes:   slow start-up cut to 20 cycles
`timescale 1ns/1ps
module sleep_idle_power_control_bench;
  logic        clk = 1'h0, nrst = 1'h0, halt_exec = 1'h0, watchdog_timeout = 1'h0, fire = 1'h0;
  logic        slow_osc_sel = 1'h1, monitor_en = 1'h1, irq_sleep_src = 1'h1, irq_pend;
  logic        cpu_halted, cpu_clk_en, clock_failure_monitor;
  logic        brownout_reset_circuit, watchdog_clear, pin_hold;
  logic [1:0]  pwr_state;
  logic [2:0]  cpu_prio = 3'h3, irq_prio = 3'h3;
  logic [3:0]  cpu_div = 4'h1;
  logic [6:0]  pbus_off = 7'h00, peripheral_bus_clock_n;
  logic [7:0]  oscillator_control_reg = 8'h00, stop_in_idle_bit = 8'h0f;
  logic [7:0]  sleep_capable = 8'h3c, periph_run;
  logic [27:0] pbus_div = 28'h0;
  int          error_cnt = 0, tests_run = 0;
  always #50 clk = ~clk;
  spc_power_ctrl #(.SU_SLOW(20)) DUT (.*);
  spc_irq_model irq_m (.*);
  ////////////////////////////////////////
  task cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (e !== g) begin
      error_cnt++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  // hold, halted, monitor, state
  task st(input logic [7:0] e);
    chk("state", e, {3'h0, pin_hold, cpu_halted, clock_failure_monitor, pwr_state});
  endtask
  task automatic hit(ref logic s, input int n);
    s = 1'h1;
    cyc(1);
    s = 1'h0;
    if (n > 0) cyc(n);
  endtask
  task t_scale;
    int a = 0, b = 0;
    pbus_div[3:0] = 4'h2;
    pbus_off[1] = 1'h1;
    cyc(3);
    repeat (30) begin
      cyc(1);
      a += cpu_clk_en;
      b += peripheral_bus_clock_n[0] + 8 * peripheral_bus_clock_n[1];
    end
    chk("cpu_en", 8'h0f, 8'(a));
    chk("bus_en", 8'h0a, 8'(b));
  endtask
  task t_idle;
    hit(halt_exec, 0);
    st(8'h0d);
    chk("run", 8'hf0, periph_run);
    hit(fire, 1);
    hit(halt_exec, 0);
    st(8'h0d);
    irq_prio = 3'h4;
    cyc(1);
    st(8'h04);
  endtask
  task t_sleep;
    oscillator_control_reg[4] = 1'h1;
    irq_prio = 3'h2;
    hit(halt_exec, 0);
    st(8'h1a);
    chk("keep", 8'h3c, periph_run);
    chk("bor_wd", 8'h02, {brownout_reset_circuit, watchdog_clear});
    irq_sleep_src = 1'h0;
    hit(fire, 1);
    st(8'h1a);
    irq_sleep_src = 1'h1;
    cyc(1);
    st(8'h0d);
    hit(watchdog_timeout, 0);
    st(8'h04);
  endtask
  task t_wake;
    int n = 0;
    irq_prio = 3'h5;
    hit(halt_exec, 0);
    hit(fire, 1);
    st(8'h1b);
    while (pwr_state === 2'h3 && n < 50) begin
      cyc(1);
      n++;
    end
    chk("su_len", 8'h01, 8'(n > 18 && n < 22));
    st(8'h04);
    hit(halt_exec, 0);
    nrst = 1'h0;
    cyc(1);
    st(8'h00);
    nrst = 1'h1;
    // fast oscillator start-up is 10 cycles
    slow_osc_sel = 1'h0;
    hit(halt_exec, 0);
    hit(watchdog_timeout, 0);
    st(8'h1b);
    n = 0;
    while (pwr_state === 2'h3 && n < 50) begin
      cyc(1);
      n++;
    end
    chk("su_fast", 8'h0a, 8'(n));
  endtask
  initial begin
    cyc(2);
    nrst = 1'h1;
    t_scale;
    t_idle;
    t_sleep;
    t_wake;
    cyc(1);
    results;
  end
  // tests need some 83 cycles
  initial begin
    repeat (2000) @(posedge clk);
    error_cnt++;
    results;
  end
  task results;
    if (error_cnt == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
endmodule // sleep_idle_power_control_bench
